// ---- common/tmr_pkg.sv ----
/*
 * Constants, field layouts and carriers for the dual 8-bit timer control block.
 * Assumes a 10 MHz pclk that also stands in for the high frequency clock,
 * and an APB master with 32-bit data.
 */
package tmr_pkg;
	// =========================================================
	// Clock and bus
	// =========================================================
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned PRE_W = 11;
	// =========================================================
	// Register indices, byte address is four times the index
	// =========================================================
	localparam logic [7:0] IDX_CTL1 = 8'h1a;
	localparam logic [7:0] IDX_CTL2 = 8'h1b;
	localparam logic [7:0] IDX_PER1 = 8'h1c;
	localparam logic [7:0] IDX_PW1 = 8'h1d;
	localparam logic [7:0] IDX_PER2 = 8'h1e;
	localparam logic [7:0] IDX_PW2 = 8'h1f;
	localparam logic [7:0] IDX_OPT = 8'h20;
	localparam logic [7:0] IDX_STAT = 8'h21;
	localparam logic [7:0] IDX_MASK = 8'h22;
	localparam logic [7:0] IDX_CNT = 8'h23;
	// Reset values
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] REG_RST = 8'h00;
	// Option and status bit positions
	localparam int unsigned OPT_DIV = 0;
	localparam int unsigned OPT_SLOW = 1;
	localparam int unsigned ST_HIT1 = 0;
	localparam int unsigned ST_HIT2 = 1;
	// =========================================================
	// Field codes
	// =========================================================
	localparam logic [2:0] CK_SLOWEST = 3'h0;
	localparam logic [2:0] CK_DIV7 = 3'h1;
	localparam logic [2:0] CK_DIV5 = 3'h2;
	localparam logic [2:0] CK_DIV3 = 3'h3;
	localparam logic [2:0] CK_FS = 3'h4;
	localparam logic [2:0] CK_DIV1 = 3'h5;
	localparam logic [2:0] CK_FC = 3'h6;
	localparam logic [2:0] CK_PIN = 3'h7;
	localparam logic [2:0] MODE_TIMER = 3'h0;
	localparam logic [2:0] MODE_PDO = 3'h1;
	localparam logic [2:0] MODE_PWM = 3'h2;
	localparam logic [2:0] MODE_CASC = 3'h3;
	localparam logic [15:0] TOP8 = 16'h00ff;
	localparam logic [15:0] TOP16 = 16'hffff;
	// =========================================================
	// Carriers
	// =========================================================
	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic flop;
		logic [2:0] clk_sel;
		logic run;
		logic [2:0] mode;
	} ctl_s;
	// One counting step result
	typedef struct packed {
		logic [15:0] cnt;
		logic out;
		logic hit;
	} step_s;
endpackage

// ---- rtl/dual_timer_ctl.sv ----
/*
 * Dual cascadable 8-bit timer control with APB register access.
 * Assumes one 10 MHz clock; the low clock and count pins arrive
 * asynchronously and are synchronised here.
 */
// Added by the designer: register access over APB.
module dual_timer_ctl
	import tmr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tmr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fs_pin,
	input wire logic ext1_pin,
	input wire logic ext2_pin,
	output logic tc_out1,
	output logic tc_out2,
	output logic irq
);
	import tmr_pkg::*;

	// =========================================================
	// Pin synchronisers
	// =========================================================
	logic [2:0] meta_r; // First stage, read only by second
	logic [2:0] sync_r; // Second stage
	logic [2:0] last_r; // Edge memory
	logic [2:0] edge_w; // Rising edges: fs, ext1, ext2

	// Two flops per pin, then edge memory
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= 3'h0;
			sync_r <= 3'h0;
			last_r <= 3'h0;
		end
		else
		begin
			meta_r <= {ext2_pin, ext1_pin, fs_pin};
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end
	assign edge_w = sync_r & ~last_r;

	// =========================================================
	// Registers
	// =========================================================
	ctl_s ctl1_r, ctl1_nxt; // First timer control
	ctl_s ctl2_r, ctl2_nxt; // Second timer control
	logic [7:0] per1_r, per1_nxt, pw1_r, pw1_nxt; // First period and width
	logic [7:0] per2_r, per2_nxt, pw2_r, pw2_nxt; // Second period and width
	logic [1:0] opt_r, opt_nxt; // Divider option, low speed
	logic [1:0] stat_r, stat_nxt; // Sticky events
	logic [1:0] mask_r, mask_nxt; // Interrupt enables
	logic [31:0] rd_r, rd_nxt; // Read data
	logic [7:0] idx_w; // Word index
	logic hit_idx; // Address is mapped
	logic wr_w, rd_w, setup_w; // Bus strobes
	logic [1:0] ev_w; // Counter events
	logic [7:0] cnt1_r, cnt1_nxt, cnt2_r, cnt2_nxt; // Counters, read through CNT

	assign idx_w = paddr[9:2];
	assign hit_idx = (paddr[ADDR_W-1:10] == '0) && idx_w >= IDX_CTL1 && idx_w <= IDX_CNT;
	assign setup_w = psel && !penable;
	assign wr_w = psel && penable && pwrite && hit_idx;
	assign rd_w = psel && penable && !pwrite;

	// Register updates and read capture
	always_comb
	begin
		ctl1_nxt = ctl1_r;
		ctl2_nxt = ctl2_r;
		per1_nxt = per1_r;
		pw1_nxt = pw1_r;
		per2_nxt = per2_r;
		pw2_nxt = pw2_r;
		opt_nxt = opt_r;
		mask_nxt = mask_r;
		rd_nxt = rd_r;
		stat_nxt = stat_r;
		// Read of status clears only the bits it returned, so an event
		// landing between setup and access is not lost
		if (rd_w && idx_w == IDX_STAT)
			stat_nxt = stat_r & ~rd_r[1:0];
		// New events win over the clear
		stat_nxt = stat_nxt | ev_w;
		if (wr_w)
		begin
			case (idx_w)
				IDX_CTL1: ctl1_nxt = pwdata[7:0];
				IDX_CTL2: ctl2_nxt = pwdata[7:0];
				IDX_PER1: per1_nxt = pwdata[7:0];
				IDX_PW1: pw1_nxt = pwdata[7:0];
				IDX_PER2: per2_nxt = pwdata[7:0];
				IDX_PW2: pw2_nxt = pwdata[7:0];
				IDX_OPT: opt_nxt = pwdata[1:0];
				IDX_MASK: mask_nxt = pwdata[1:0];
				default: opt_nxt = opt_r;
			endcase
		end
		// Read data latched in the setup cycle
		if (setup_w)
		begin
			case (idx_w)
				IDX_CTL1: rd_nxt = {24'h0, ctl1_r};
				IDX_CTL2: rd_nxt = {24'h0, ctl2_r};
				IDX_PER1: rd_nxt = {24'h0, per1_r};
				IDX_PW1: rd_nxt = {24'h0, pw1_r};
				IDX_PER2: rd_nxt = {24'h0, per2_r};
				IDX_PW2: rd_nxt = {24'h0, pw2_r};
				IDX_OPT: rd_nxt = {30'h0, opt_r};
				IDX_STAT: rd_nxt = {30'h0, stat_r};
				IDX_MASK: rd_nxt = {30'h0, mask_r};
				IDX_CNT: rd_nxt = {14'h0, tc_out2, tc_out1, cnt2_r, cnt1_r};
				default: rd_nxt = 32'h0;
			endcase
		end
	end

	// Register storage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl1_r <= CTL_RST;
			ctl2_r <= CTL_RST;
			per1_r <= REG_RST;
			pw1_r <= REG_RST;
			per2_r <= REG_RST;
			pw2_r <= REG_RST;
			opt_r <= 2'h0;
			stat_r <= 2'h0;
			mask_r <= 2'h0;
			rd_r <= 32'h0;
		end
		else
		begin
			ctl1_r <= ctl1_nxt;
			ctl2_r <= ctl2_nxt;
			per1_r <= per1_nxt;
			pw1_r <= pw1_nxt;
			per2_r <= per2_nxt;
			pw2_r <= pw2_nxt;
			opt_r <= opt_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Zero wait state answer
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_idx;
	assign prdata = rd_r;
	assign irq = |(stat_r & mask_r);

	// =========================================================
	// Count clocks
	// =========================================================
	logic tick1, tick2; // Selected count ticks
	logic casc; // Cascaded 16-bit operation

	assign casc = ctl1_r.mode == MODE_CASC;

	tick_select u_tick1 (
		.pclk(pclk),
		.presetn(presetn),
		.clk_sel(ctl1_r.clk_sel),
		.div_opt(opt_r[OPT_DIV]),
		.slow(opt_r[OPT_SLOW]),
		.fs_tick(edge_w[0]),
		.ext_tick(edge_w[1]),
		.tick(tick1)
	);

	tick_select u_tick2 (
		.pclk(pclk),
		.presetn(presetn),
		.clk_sel(ctl2_r.clk_sel),
		.div_opt(opt_r[OPT_DIV]),
		.slow(opt_r[OPT_SLOW]),
		.fs_tick(edge_w[0]),
		.ext_tick(edge_w[2]),
		.tick(tick2)
	);

	// =========================================================
	// Counters and output flops
	// =========================================================
	logic out1_r, out1_nxt, out2_r, out2_nxt; // Timer flops
	logic run1, run2; // Effective run bits
	step_s s1, s2, s16; // Step results

	// One tick of counting in a given mode
	function automatic step_s step(input logic [15:0] cnt, input logic [15:0] per,
		input logic [15:0] pw, input logic [2:0] mode, input logic [15:0] top,
		input logic out, input logic flop);
		step_s r;
		logic [15:0] inc;
		r.cnt = cnt;
		r.out = out;
		r.hit = 1'b0;
		inc = cnt + 16'h0001;
		case (mode)
			// Timer and divider: clear on period match
			MODE_TIMER, MODE_PDO:
			begin
				r.cnt = (inc == per) ? 16'h0000 : (inc & top);
				r.hit = inc == per;
				if (mode == MODE_PDO && inc == per)
					r.out = !out;
			end
			// PWM: flip at width, restore at wrap
			MODE_PWM:
			begin
				r.cnt = (cnt == top) ? 16'h0000 : inc;
				if (cnt == pw)
				begin
					r.out = !out;
					r.hit = 1'b1;
				end
				if (cnt == top)
					r.out = flop;
			end
			// Reserved codes hold
			default: r.hit = 1'b0;
		endcase
		return r;
	endfunction

	assign run1 = casc ? ctl2_r.run : ctl1_r.run;
	assign run2 = ctl2_r.run;
	assign s16 = step({cnt2_r, cnt1_r}, {per2_r, per1_r}, {pw2_r, pw1_r}, ctl2_r.mode,
		TOP16, out2_r, ctl2_r.flop);
	assign s1 = step({8'h00, cnt1_r}, {8'h00, per1_r}, {8'h00, pw1_r}, ctl1_r.mode,
		TOP8, out1_r, ctl1_r.flop);
	assign s2 = step({8'h00, cnt2_r}, {8'h00, per2_r}, {8'h00, pw2_r}, ctl2_r.mode,
		TOP8, out2_r, ctl2_r.flop);

	// Next counter and flop values
	always_comb
	begin
		cnt1_nxt = cnt1_r;
		cnt2_nxt = cnt2_r;
		out1_nxt = out1_r;
		out2_nxt = out2_r;
		ev_w = 2'h0;
		if (casc)
		begin
			if (!run2)
			begin
				cnt1_nxt = 8'h00;
				cnt2_nxt = 8'h00;
				out2_nxt = ctl2_r.flop;
			end
			else if (tick1)
			begin
				cnt1_nxt = s16.cnt[7:0];
				cnt2_nxt = s16.cnt[15:8];
				out2_nxt = s16.out;
				ev_w[ST_HIT2] = s16.hit;
			end
		end
		else
		begin
			if (!ctl1_r.run)
			begin
				cnt1_nxt = 8'h00;
				out1_nxt = ctl1_r.flop;
			end
			else if (tick1)
			begin
				cnt1_nxt = s1.cnt[7:0];
				out1_nxt = s1.out;
				ev_w[ST_HIT1] = s1.hit;
			end
			if (!run2)
			begin
				cnt2_nxt = 8'h00;
				out2_nxt = ctl2_r.flop;
			end
			else if (tick2)
			begin
				cnt2_nxt = s2.cnt[7:0];
				out2_nxt = s2.out;
				ev_w[ST_HIT2] = s2.hit;
			end
		end
	end

	// Counter storage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt1_r <= 8'h00;
			cnt2_r <= 8'h00;
			out1_r <= 1'b0;
			out2_r <= 1'b0;
		end
		else
		begin
			cnt1_r <= cnt1_nxt;
			cnt2_r <= cnt2_nxt;
			out1_r <= out1_nxt;
			out2_r <= out2_nxt;
		end
	end
	assign tc_out1 = out1_r;
	assign tc_out2 = out2_r;

	// =========================================================
	// Checks
	// =========================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_stop_clears: assert property (!run1 |=> cnt1_r == 8'h00)
		else $error("stopped counter not cleared");
	a_stop_flop: assert property (!casc && !ctl1_r.run |=> out1_r == $past(ctl1_r.flop))
		else $error("stopped flop not set from control");
	a_casc_run: assert property (casc && ctl1_r.run && !ctl2_r.run |=> cnt1_r == 8'h00)
		else $error("cascade ignores second run bit");
	a_ctl_write: assert property (wr_w && idx_w == IDX_CTL1 |=> ctl1_r == $past(pwdata[7:0]))
		else $error("control write lost");
	a_irq_level: assert property (|(ev_w & mask_r) && !(wr_w && idx_w == IDX_MASK) |=> irq)
		else $error("enabled event gave no interrupt");
	a_event_sticky: assert property (ev_w[ST_HIT1] |=> stat_r[ST_HIT1]
		##1 (stat_r[ST_HIT1] || $past(rd_w && idx_w == IDX_STAT)))
		else $error("event lost");
	a_pdo_toggle: assert property (!casc && ctl1_r.run && tick1 && ctl1_r.mode == MODE_PDO
		&& {1'b0, cnt1_r} + 9'h001 == {1'b0, per1_r} |=> out1_r != $past(out1_r))
		else $error("divider output did not toggle");
	a_casc_carry: assert property (casc && run2 && tick1 && ctl2_r.mode == MODE_TIMER
		&& {cnt2_r, cnt1_r} + 16'h0001 != {per2_r, per1_r}
		|=> {cnt2_r, cnt1_r} == $past({cnt2_r, cnt1_r}) + 16'h0001)
		else $error("cascade counter did not carry");

	c_pdo: cover property (ctl1_r.mode == MODE_PDO && ev_w[ST_HIT1]);
	c_pwm: cover property (ctl2_r.mode == MODE_PWM && ev_w[ST_HIT2]);
	c_casc: cover property (casc && ev_w[ST_HIT2]);
endmodule

// ---- rtl/tick_select.sv ----
/*
 * Count clock selection for one timer: prescaler of the fast clock,
 * low clock divider, and the external count tick.
 * Assumes fs_tick and ext_tick are already synchronised one-cycle pulses.
 */
module tick_select
	import tmr_pkg::*;
#(
	parameter int unsigned PW = PRE_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] clk_sel,
	input wire logic div_opt,
	input wire logic slow,
	input wire logic fs_tick,
	input wire logic ext_tick,
	output logic tick
);
	// =========================================================
	// Prescaler state
	// =========================================================
	logic [PW-1:0] pre_r; // Fast clock divider
	logic [PW-1:0] pre_nxt;
	logic [2:0] fs8_r; // Low clock divide by eight
	logic [2:0] fs8_nxt;

	// Next values of both dividers
	always_comb
	begin
		pre_nxt = pre_r + 1'b1;
		fs8_nxt = fs_tick ? fs8_r + 3'h1 : fs8_r;
	end

	// Register the dividers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_r <= '0;
			fs8_r <= 3'h0;
		end
		else
		begin
			pre_r <= pre_nxt;
			fs8_r <= fs8_nxt;
		end
	end

	// =========================================================
	// Clock mux
	// =========================================================
	// Code to tick
	always_comb
	begin
		case (clk_sel)
			// Slowest code falls back on low clock when divider option or low speed is set
			CK_SLOWEST: tick = (div_opt || slow) ? (fs_tick && fs8_r == 3'h7) : (&pre_r[10:0]);
			CK_DIV7: tick = !slow && (&pre_r[6:0]);
			CK_DIV5: tick = !slow && (&pre_r[4:0]);
			CK_DIV3: tick = !slow && (&pre_r[2:0]);
			CK_FS: tick = fs_tick;
			CK_DIV1: tick = !slow && pre_r[0];
			CK_FC: tick = 1'b1;
			CK_PIN: tick = ext_tick;
			default: tick = 1'b0;
		endcase
	end

	// =========================================================
	// Checks
	// =========================================================
	a_fast_tick: assert property (@(posedge pclk) disable iff (!presetn)
		clk_sel == CK_FC |-> tick) else $error("fast code gives no tick");
	a_slow_block: assert property (@(posedge pclk) disable iff (!presetn)
		(slow && clk_sel == CK_DIV3) |-> !tick) else $error("divided code ticks when slow");
endmodule

// ---- verification/tb_top.sv ----
/*
 * Self-checking bench for the dual timer control block over APB.
 * Assumes tmr_pkg and the design files are compiled before it.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import tmr_pkg::*;
	// =========================================================
	// Signals
	// =========================================================
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic fs_pin = 1'b0;
	logic ext1_pin = 1'b0;
	logic ext2_pin = 1'b0;
	logic tc_out1;
	logic tc_out2;
	logic irq;
	logic slv_seen; // Error flag of last transfer
	logic [31:0] rd; // Last read word
	int error_cnt = 0;
	int cmp_count = 0;
	int tog1 = 0; // Output one transitions
	logic prev1 = 1'b0;
	dual_timer_ctl dual_timer_ctl_inst (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.fs_pin(fs_pin),
		.ext1_pin(ext1_pin),
		.ext2_pin(ext2_pin),
		.tc_out1(tc_out1),
		.tc_out2(tc_out2),
		.irq(irq)
	);
	// Clock, 100 ns period
	initial
	begin
		forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
	end
	// Counts output transitions, sampled when settled
	always @(negedge pclk)
	begin
		if (tc_out1 !== prev1)
			tog1 = tog1 + 1;
		prev1 = tc_out1;
	end
	// =========================================================
	// Tasks
	// =========================================================
	task automatic report_and_stop();
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer: setup, then access until pready
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n >= 16)
		begin
			error_cnt++;
			$display("MISMATCH pready expected 1 seen %b", pready);
			report_and_stop();
		end
		rd = prdata;
		slv_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] ctl(input logic f, input logic [2:0] ck, input logic r,
		input logic [2:0] m);
		ctl_s c;
		c = '{flop: f, clk_sel: ck, run: r, mode: m};
		return {24'h00_0000, c};
	endfunction
	// Fields set while stopped, then started in one write
	task automatic start1(input logic [2:0] ck, input logic [2:0] m);
		apb(1'b1, IDX_CTL1, ctl(1'b0, ck, 1'b0, m));
		apb(1'b1, IDX_CTL1, ctl(1'b0, ck, 1'b1, m));
	endtask
	// Stop with unchanged fields; counter must read zero
	task automatic stop1(input logic [2:0] ck, input logic [2:0] m);
		apb(1'b1, IDX_CTL1, ctl(1'b0, ck, 1'b0, m));
		apb(1'b0, IDX_CNT, 0);
		chk("stopped cnt1", 0, {24'h00_0000, rd[7:0]});
	endtask
	// Counter advance over a whole number of tick periods
	task automatic rate(input logic [2:0] ck, input int dv, input int k);
		logic [7:0] a;
		start1(ck, MODE_TIMER);
		apb(1'b0, IDX_CNT, 0);
		a = rd[7:0];
		repeat (dv * k - 3) @(posedge pclk);
		apb(1'b0, IDX_CNT, 0);
		chk("cnt1 rate", {24'h00_0000, a + k[7:0]}, {24'h00_0000, rd[7:0]});
		stop1(ck, MODE_TIMER);
	endtask
	// Pulses on a pin: 0 low clock, 1 first count pin, 2 second
	task automatic pulse(input int which, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			fs_pin <= (which == 0);
			ext1_pin <= (which == 1);
			ext2_pin <= (which == 2);
			repeat (3) @(posedge pclk);
			fs_pin <= 1'b0;
			ext1_pin <= 1'b0;
			ext2_pin <= 1'b0;
			repeat (2) @(posedge pclk);
		end
		repeat (6) @(posedge pclk);
	endtask
	// =========================================================
	// Main sequence
	// =========================================================
	initial
	begin
		logic [31:0] v;
		logic [15:0] a;
		int p;
		int t;
		void'($urandom(32'he4815b96));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			apb(1'b0, IDX_CTL1 + i[7:0], 0);
			chk("reset value", 0, rd);
		end
		// Random readback with run bits clear
		for (int i = 0; i < 6; i++)
		begin
			v = $urandom() & 32'h0000_00f7;
			apb(1'b1, IDX_CTL1 + i[7:0], v);
			apb(1'b0, IDX_CTL1 + i[7:0], 0);
			chk("readback", v, rd);
			chk("mapped pslverr", 0, {31'h0, slv_seen});
			apb(1'b1, IDX_CTL1 + i[7:0], 0);
		end
		apb(1'b1, 8'h30, 32'h0000_00ff);
		chk("pslverr", 1, {31'h0, slv_seen});
		apb(1'b0, 8'h30, 0);
		chk("unmapped read", 0, rd);
		rate(CK_FC, 1, 40);
		rate(CK_DIV1, 2, 40);
		rate(CK_DIV3, 8, 40);
		rate(CK_DIV5, 32, 40);
		rate(CK_DIV7, 128, 20);
		rate(CK_SLOWEST, 2048, 4);
		p = 3 + ($urandom() % 7);
		start1(CK_PIN, MODE_TIMER);
		pulse(1, p);
		apb(1'b0, IDX_CNT, 0);
		chk("ext count", p, {24'h00_0000, rd[7:0]});
		stop1(CK_PIN, MODE_TIMER);
		start1(CK_FS, MODE_TIMER);
		pulse(0, p);
		apb(1'b0, IDX_CNT, 0);
		chk("fs count", p, {24'h00_0000, rd[7:0]});
		stop1(CK_FS, MODE_TIMER);
		apb(1'b1, IDX_OPT, 32'h0000_0001);
		start1(CK_SLOWEST, MODE_TIMER);
		pulse(0, 16);
		apb(1'b0, IDX_CNT, 0);
		chk("fs div8", 2, {24'h00_0000, rd[7:0]});
		stop1(CK_SLOWEST, MODE_TIMER);
		// Low speed: divided codes stop, slowest code counts the low clock
		apb(1'b1, IDX_OPT, 32'h0000_0002);
		start1(CK_SLOWEST, MODE_TIMER);
		pulse(0, 8);
		apb(1'b0, IDX_CNT, 0);
		chk("slow fs div8", 1, {24'h00_0000, rd[7:0]});
		stop1(CK_SLOWEST, MODE_TIMER);
		apb(1'b1, IDX_OPT, 0);
		// Second timer on its own pin
		apb(1'b1, IDX_CTL2, ctl(1'b0, CK_PIN, 1'b1, MODE_TIMER));
		pulse(2, p);
		apb(1'b0, IDX_CNT, 0);
		chk("ext2 count", p, {24'h00_0000, rd[15:8]});
		apb(1'b1, IDX_CTL2, ctl(1'b0, CK_PIN, 1'b0, MODE_TIMER));
		// Period match, event and interrupt
		p = 4 + ($urandom() % 17);
		apb(1'b1, IDX_PER1, p);
		apb(1'b1, IDX_MASK, 32'h0000_0001);
		start1(CK_FC, MODE_TIMER);
		apb(1'b0, IDX_CNT, 0);
		a = rd[15:0];
		repeat (p * 5 - 3) @(posedge pclk);
		apb(1'b0, IDX_CNT, 0);
		chk("period wrap", {24'h00_0000, a[7:0]}, {24'h00_0000, rd[7:0]});
		stop1(CK_FC, MODE_TIMER);
		@(negedge pclk);
		chk("irq set", 1, {31'h0, irq});
		apb(1'b0, IDX_STAT, 0);
		chk("status", 1, rd & 32'h0000_0001);
		@(negedge pclk);
		chk("irq clear", 0, {31'h0, irq});
		apb(1'b1, IDX_MASK, 0);
		// divider output toggles once per period
		start1(CK_FC, MODE_PDO);
		repeat (10) @(posedge pclk);
		t = tog1;
		repeat (p * 6) @(posedge pclk);
		chk("pdo toggles", 6, tog1 - t);
		stop1(CK_FC, MODE_PDO);
		@(negedge pclk);
		chk("irq masked", 0, {31'h0, irq});
		// width rewritten while running in pulse mode
		apb(1'b1, IDX_PW1, 10 + ($urandom() % 100));
		start1(CK_FC, MODE_PWM);
		apb(1'b1, IDX_PW1, 120 + ($urandom() % 80));
		repeat (300) @(posedge pclk);
		t = tog1;
		repeat (512) @(posedge pclk);
		chk("pwm toggles", 4, tog1 - t);
		stop1(CK_FC, MODE_PWM);
		// Reserved mode holds the counter
		start1(CK_FC, 3'h5);
		repeat (20) @(posedge pclk);
		apb(1'b0, IDX_CNT, 0);
		chk("reserved hold", 0, {24'h00_0000, rd[7:0]});
		stop1(CK_FC, 3'h5);
		// cascade, clock from first, run from second
		apb(1'b1, IDX_PER1, 0);
		apb(1'b1, IDX_CTL1, ctl(1'b0, CK_FC, 1'b0, MODE_CASC));
		apb(1'b1, IDX_CTL2, ctl(1'b0, CK_SLOWEST, 1'b1, MODE_TIMER));
		apb(1'b0, IDX_CNT, 0);
		a = rd[15:0];
		repeat (997) @(posedge pclk);
		apb(1'b0, IDX_CNT, 0);
		chk("cascade cnt", {16'h0000, a + 16'd1000}, {16'h0000, rd[15:0]});
		apb(1'b1, IDX_CTL2, ctl(1'b0, CK_SLOWEST, 1'b0, MODE_TIMER));
		apb(1'b1, IDX_CTL2, ctl(1'b1, CK_SLOWEST, 1'b0, MODE_TIMER));
		// Flop follows the control bit one edge after the write
		@(posedge pclk);
		@(negedge pclk);
		chk("cascade flop", 1, {31'h0, tc_out2});
		apb(1'b1, IDX_CTL1, ctl(1'b1, CK_FC, 1'b0, MODE_TIMER));
		@(posedge pclk);
		@(negedge pclk);
		chk("stopped flop", 1, {31'h0, tc_out1});
		report_and_stop();
	end
endmodule
